// ---- inc/ghs_pkg.sv ----
package ghs_pkg;
  localparam int CLK_MHZ = 200;
  localparam int WORD_W = 16;
  localparam int ADDR_LSB = 13;
  localparam logic [2:0] ADDR_SEEK_CMD = 3'h4;
  localparam logic [2:0] ADDR_SEEK_CFG = 3'h5;
  localparam int CMD_GAUGE_BIT = 0;
  localparam int CMD_ENABLE_BIT = 1;
  localparam int CMD_SLICE_LSB = 2;
  localparam int CMD_UNCOND_BIT = 4;
  localparam int CMD_RSVD_LSB = 5;
  localparam int CMD_RSVD_MSB = 12;
  localparam int CFG_STEP_LSB = 0;
  localparam int CFG_BLANK_BIT = 4;
  localparam int CFG_PRELOAD_LSB = 5;
  localparam int ST_ACTIVE_LSB = 2;
  localparam int ST_SLICE_LSB = 8;
  localparam logic [3:0] STEP_SEL_RST = 4'h5;
  localparam logic BLANK_SEL_RST = 1'h0;
  localparam logic [7:0] PRELOAD_RST = 8'h00;
  localparam logic [1:0] SLICE_RST = 2'h0;
  localparam logic [14:0] ACC_RST = 15'h0000;
  localparam logic [14:0] ACC_FIRST = 15'h7FFF;
  localparam logic [14:0] ACC_MAX = 15'h3FFF;
  localparam logic [14:0] ACC_MIN = 15'h4000;
  localparam int TMR_W = 24;
  localparam int BLANK_SHORT_US = 512;
  localparam int BLANK_LONG_US = 768;
  localparam int SD_SAMPLE_US = 1;
  localparam int STEP_UNIT_US = 10;
  // Full step times in units of 10 us, 4.86 ms up to 62.21 ms.
  localparam int STEP_TIME_10US [16] = '{486, 486, 896, 1306, 1715, 2125, 2534, 2944,
                                         3354, 3763, 4173, 4582, 4992, 5402, 5811, 6221};
  typedef enum logic [1:0] {seek_idle, seek_blank, seek_integ} ghs_seek_t;
endpackage : ghs_pkg

// ---- inc/ghs_spi_if.sv ----
`timescale 1ns/1ps
interface ghs_spi_if;
  logic [ghs_pkg::WORD_W-1:0] word;
  logic word_valid;
  logic [ghs_pkg::WORD_W-1:0] status;
  logic miso;
  logic miso_oe;
  modport rx (output word, output word_valid, output miso, output miso_oe, input status);
  modport core (input word, input word_valid, input miso, input miso_oe, output status);
endinterface : ghs_spi_if

// ---- hdl/ghs_spi_rx.sv ----
`timescale 1ns/1ps
module ghs_spi_rx (
  input wire logic clock, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, low freezes all state.
  input wire logic sclk, // Serial clock pin.
  input wire logic cs_n, // Chip select pin, active low.
  input wire logic mosi, // Serial data in pin.
  ghs_spi_if.rx bus // Received word and status word.
);
  // Bit order in the pin vectors is {cs_n, sclk, mosi}.
  logic [2:0] pin_meta, pin_sync, pin_prev;
  logic [ghs_pkg::WORD_W-1:0] shift, next_shift, next_word;
  logic [3:0] cnt, next_cnt;
  logic any, next_any, next_valid, next_miso, next_oe;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  always_comb begin
    sclk_rise = pin_sync[1] && !pin_prev[1] && !pin_sync[2];
    sclk_fall = !pin_sync[1] && pin_prev[1] && !pin_sync[2];
    cs_fall = !pin_sync[2] && pin_prev[2];
    cs_rise = pin_sync[2] && !pin_prev[2];
    next_shift = shift;
    next_cnt = cnt;
    next_any = any;
    next_word = bus.word;
    next_valid = 1'b0;
    next_miso = bus.miso;
    next_oe = bus.miso_oe;
    if (cs_fall) begin
      next_shift = bus.status;
      next_miso = bus.status[ghs_pkg::WORD_W-1];
      next_oe = 1'b1;
      next_cnt = 4'h0;
      next_any = 1'b0;
    end else if (sclk_rise) begin
      // Bits past the sixteenth carry the first bits taken in, which allows daisy chains.
      next_shift = {shift[ghs_pkg::WORD_W-2:0], pin_sync[0]};
      next_cnt = cnt + 4'h1;
      next_any = 1'b1;
    end else if (sclk_fall) begin
      next_miso = shift[ghs_pkg::WORD_W-1];
    end
    if (cs_rise) begin
      next_oe = 1'b0;
      if (any && cnt == 4'h0) begin
        next_valid = 1'b1;
        next_word = shift;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      pin_prev <= 3'h7;
      shift <= 16'h0000;
      cnt <= 4'h0;
      any <= 1'b0;
      bus.word <= 16'h0000;
      bus.word_valid <= 1'b0;
      bus.miso <= 1'b0;
      bus.miso_oe <= 1'b0;
    end else if (ce) begin
      pin_meta <= {cs_n, sclk, mosi};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      shift <= next_shift;
      cnt <= next_cnt;
      any <= next_any;
      bus.word <= next_word;
      bus.word_valid <= next_valid;
      bus.miso <= next_miso;
      bus.miso_oe <= next_oe;
    end
  end
endmodule : ghs_spi_rx

// ---- hdl/ghs_top.sv ----
`timescale 1ns/1ps
module ghs_top #(
  parameter int unsigned CYC_PER_US = ghs_pkg::CLK_MHZ // Clock cycles per microsecond.
) (
  input wire logic clock, // System clock, 200 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, low freezes all state.
  input wire logic spi_sclk, // Serial clock from the host.
  input wire logic spi_cs_n, // Chip select from the host, active low.
  input wire logic spi_mosi, // Serial data from the host.
  output logic spi_miso, // Serial status data to the host.
  output logic spi_miso_oe, // High while the status pin is driven.
  input wire logic [1:0] bemf_bit, // Sigma-delta bit of each gauge's open coil.
  output logic [1:0] coil_a_en, // Coil A driven, per gauge.
  output logic [1:0] coil_a_neg, // Coil A current reversed, per gauge.
  output logic [1:0] coil_b_en, // Coil B driven, per gauge.
  output logic [1:0] coil_b_neg // Coil B current reversed, per gauge.
);
  localparam int SD_CYC = ghs_pkg::SD_SAMPLE_US * CYC_PER_US;
  localparam int BLANK_SHORT_CYC = ghs_pkg::BLANK_SHORT_US * CYC_PER_US;
  localparam int BLANK_LONG_CYC = ghs_pkg::BLANK_LONG_US * CYC_PER_US;
  localparam int STEP_UNIT_CYC = ghs_pkg::STEP_UNIT_US * CYC_PER_US;

  ghs_spi_if spi ();

  ghs_spi_rx u_spi (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .bus(spi.rx)
  );

  assign spi_miso = spi.miso;
  assign spi_miso_oe = spi.miso_oe;

  logic [2:0] addr;
  logic cmd_hit, cfg_hit;
  logic start [2];
  logic stop [2];
  logic step_done [2];
  logic [14:0] step_res [2];
  logic [1:0] seek_active;
  logic [3:0] step_sel, next_step_sel;
  logic blank_sel, next_blank_sel;
  logic [7:0] preload, next_preload;
  logic [1:0] slice_sel, next_slice_sel;
  logic [14:0] reported, next_reported;
  logic [14:0] acc_init;
  logic [ghs_pkg::TMR_W-1:0] step_cyc, blank_cyc;
  logic [15:0] sd_cnt, next_sd_cnt;
  logic sd_tick;
  logic [7:0] slice;

  always_comb begin
    addr = spi.word[ghs_pkg::WORD_W-1:ghs_pkg::ADDR_LSB];
    // A seek command with reserved bits set is not decoded; like any valid word, it still clears a stalled gauge's active flag.
    cmd_hit = spi.word_valid && addr == ghs_pkg::ADDR_SEEK_CMD
              && spi.word[ghs_pkg::CMD_RSVD_MSB:ghs_pkg::CMD_RSVD_LSB] == 8'h00;
    cfg_hit = spi.word_valid && addr == ghs_pkg::ADDR_SEEK_CFG;
    acc_init = ~{3'h0, preload, 4'h0};
    step_cyc = ghs_pkg::TMR_W'(ghs_pkg::STEP_TIME_10US[step_sel] * STEP_UNIT_CYC);
    blank_cyc = blank_sel ? ghs_pkg::TMR_W'(BLANK_LONG_CYC) : ghs_pkg::TMR_W'(BLANK_SHORT_CYC);
    sd_tick = sd_cnt == 16'(SD_CYC - 1);
    next_sd_cnt = sd_tick ? 16'h0000 : sd_cnt + 16'h0001;
  end

  always_comb begin
    next_step_sel = step_sel;
    next_blank_sel = blank_sel;
    next_preload = preload;
    next_slice_sel = slice_sel;
    next_reported = reported;
    if (cfg_hit) begin
      next_step_sel = spi.word[ghs_pkg::CFG_STEP_LSB +: 4];
      next_blank_sel = spi.word[ghs_pkg::CFG_BLANK_BIT];
      next_preload = spi.word[ghs_pkg::CFG_PRELOAD_LSB +: 8];
    end
    // The slice follows every valid seek command, whatever the motion is doing.
    if (cmd_hit) begin
      next_slice_sel = spi.word[ghs_pkg::CMD_SLICE_LSB +: 2];
    end
    if (start[0] || start[1]) begin
      next_reported = ghs_pkg::ACC_FIRST;
    end
    // Gauge 1 wins when both gauges end a step in the same cycle.
    for (int g = 0; g < 2; g++) begin
      if (step_done[g] && !start[g]) begin
        next_reported = step_res[g];
      end
    end
  end

  always_comb begin
    case (slice_sel)
      2'h0: slice = reported[7:0];
      2'h1: slice = reported[11:4];
      default: slice = {1'b0, reported[14:8]};
    endcase
    spi.status = 16'h0000;
    spi.status[ghs_pkg::ST_SLICE_LSB +: 8] = slice;
    spi.status[ghs_pkg::ST_ACTIVE_LSB +: 2] = seek_active;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      step_sel <= ghs_pkg::STEP_SEL_RST;
      blank_sel <= ghs_pkg::BLANK_SEL_RST;
      preload <= ghs_pkg::PRELOAD_RST;
      slice_sel <= ghs_pkg::SLICE_RST;
      reported <= ghs_pkg::ACC_RST;
      sd_cnt <= 16'h0000;
    end else if (ce) begin
      step_sel <= next_step_sel;
      blank_sel <= next_blank_sel;
      preload <= next_preload;
      slice_sel <= next_slice_sel;
      reported <= next_reported;
      sd_cnt <= next_sd_cnt;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_gauge
    ghs_pkg::ghs_seek_t st, next_st;
    logic [ghs_pkg::TMR_W-1:0] tmr, next_tmr;
    logic [14:0] acc, next_acc, acc_f;
    logic [1:0] phase, next_phase;
    logic [3:0] coil, next_coil;
    logic uncond, next_uncond, active, next_active, stalled, next_stalled;
    logic bemf_meta, bemf_sync;
    logic flip;

    always_comb begin
      start[g] = cmd_hit && spi.word[ghs_pkg::CMD_GAUGE_BIT] == 1'(g)
                 && spi.word[ghs_pkg::CMD_ENABLE_BIT];
      stop[g] = cmd_hit && spi.word[ghs_pkg::CMD_GAUGE_BIT] == 1'(g)
                && !spi.word[ghs_pkg::CMD_ENABLE_BIT];
      // Saturation keeps a long step from wrapping a stall into a false move.
      acc_f = acc;
      if (sd_tick) begin
        if (bemf_sync && acc != ghs_pkg::ACC_MAX) begin
          acc_f = acc + 15'h0001;
        end else if (!bemf_sync && acc != ghs_pkg::ACC_MIN) begin
          acc_f = acc - 15'h0001;
        end
      end
      next_st = st;
      next_tmr = tmr;
      next_acc = acc;
      next_phase = phase;
      next_uncond = uncond;
      next_active = active;
      next_stalled = stalled;
      step_done[g] = 1'b0;
      step_res[g] = acc_f;
      if (spi.word_valid && stalled) begin
        next_active = 1'b0;
        next_stalled = 1'b0;
      end
      case (st)
        ghs_pkg::seek_idle: begin
          next_tmr = tmr;
        end
        ghs_pkg::seek_blank: begin
          next_tmr = tmr + ghs_pkg::TMR_W'(1);
          if (next_tmr >= blank_cyc) begin
            next_st = ghs_pkg::seek_integ;
          end
        end
        ghs_pkg::seek_integ: begin
          next_tmr = tmr + ghs_pkg::TMR_W'(1);
          next_acc = acc_f;
          if (next_tmr >= step_cyc) begin
            step_done[g] = 1'b1;
            next_tmr = {ghs_pkg::TMR_W{1'b0}};
            next_acc = acc_init;
            next_phase = phase + 2'h1;
            if (acc_f[14] && !uncond) begin
              next_st = ghs_pkg::seek_idle;
              next_stalled = 1'b1;
            end else begin
              next_st = ghs_pkg::seek_blank;
            end
          end
        end
        default: begin
          next_st = ghs_pkg::seek_idle;
        end
      endcase
      if (stop[g]) begin
        next_st = ghs_pkg::seek_idle;
        next_active = 1'b0;
        next_stalled = 1'b0;
      end
      if (start[g]) begin
        next_st = ghs_pkg::seek_blank;
        next_tmr = {ghs_pkg::TMR_W{1'b0}};
        next_acc = acc_init;
        next_uncond = spi.word[ghs_pkg::CMD_UNCOND_BIT];
        next_active = 1'b1;
        next_stalled = 1'b0;
      end
      // Phases run A+, B-, A-, B+ so the rotor turns toward the zero stop.
      flip = next_phase[1] ^ next_phase[0];
      if (next_st == ghs_pkg::seek_idle) begin
        next_coil = 4'h0;
      end else begin
        next_coil = {flip & next_phase[0], next_phase[0], flip & ~next_phase[0], ~next_phase[0]};
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        st <= ghs_pkg::seek_idle;
        tmr <= {ghs_pkg::TMR_W{1'b0}};
        acc <= ghs_pkg::ACC_RST;
        phase <= 2'h0;
        coil <= 4'h0;
        uncond <= 1'b0;
        active <= 1'b0;
        stalled <= 1'b0;
        bemf_meta <= 1'b0;
        bemf_sync <= 1'b0;
      end else if (ce) begin
        st <= next_st;
        tmr <= next_tmr;
        acc <= next_acc;
        phase <= next_phase;
        coil <= next_coil;
        uncond <= next_uncond;
        active <= next_active;
        stalled <= next_stalled;
        bemf_meta <= bemf_bit[g];
        bemf_sync <= bemf_meta;
      end
    end

    assign coil_a_en[g] = coil[0];
    assign coil_a_neg[g] = coil[1];
    assign coil_b_en[g] = coil[2];
    assign coil_b_neg[g] = coil[3];
    assign seek_active[g] = active;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_start0;
    start[0] && ce;
  endsequence

  sequence s_step_end0;
    step_done[0] && ce;
  endsequence

  a_one_coil_only: assert property (!(coil_a_en[1] && coil_b_en[1]) && !(coil_a_en[0] && coil_b_en[0]))
    else $error("both coils of one gauge driven");

  a_start_seek_state: assert property (s_start0 |=> g_gauge[0].st == ghs_pkg::seek_blank && seek_active[0])
    else $error("start command did not begin seeking");

  a_stop_seek_state: assert property (stop[0] && !start[0] && ce |=> g_gauge[0].st == ghs_pkg::seek_idle
                                      && !seek_active[0] && coil_a_en[0] == 1'b0)
    else $error("stop command did not end seeking");

  a_first_step_ones: assert property ((s_start0 and !step_done[1]) |=> reported == ghs_pkg::ACC_FIRST)
    else $error("first step does not report all ones");

  a_stall_ends_seek: assert property (s_step_end0 ##0 (step_res[0][14] && !g_gauge[0].uncond && !start[0] && !stop[0])
                                      |=> g_gauge[0].st == ghs_pkg::seek_idle && seek_active[0])
    else $error("stall did not end automatic seek");

  a_uncond_keeps_on: assert property (s_step_end0 ##0 (g_gauge[0].uncond && !stop[0] && !start[0])
                                      |=> g_gauge[0].st == ghs_pkg::seek_blank)
    else $error("unconditional seek stopped on stall");

  a_acc_reinit_step: assert property (s_step_end0 ##0 !start[0] |=> g_gauge[0].acc == $past(acc_init))
    else $error("accumulator not reloaded after a step");

  a_reserved_ignored: assert property (spi.word_valid && ce && addr == ghs_pkg::ADDR_SEEK_CMD
                                       && spi.word[ghs_pkg::CMD_RSVD_MSB:ghs_pkg::CMD_RSVD_LSB] != 8'h00
                                       && !g_gauge[0].stalled && !g_gauge[1].stalled
                                       |=> $stable(slice_sel) && $stable(seek_active))
    else $error("invalid seek command was acted on");

  a_sign_in_status: assert property (slice_sel[1] |-> spi.status[14] == reported[14])
    else $error("sign bit missing from status");
endmodule : ghs_top

// ---- test/ghs_host_model.sv ----
`timescale 1ns/1ps
module ghs_host_model (
  input wire logic clock, // System clock, used to align frame starts and to time the end-of-frame check pulse.
  output logic sclk, // Serial clock, still between frames.
  output logic cs_n, // Chip select, active low.
  output logic mosi, // Serial data to the device.
  input wire logic miso, // Serial data from the device.
  input wire logic miso_oe, // High while the device drives its data pin.
  output logic [15:0] rd_word, // First sixteen bits read in the last frame.
  output logic rd_done // One-cycle pulse when a checked frame ends.
);
  localparam realtime HALF = 62.5;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rd_word = 16'h0000;
    rd_done = 1'b0;
  end

  // Sends the low n bits of d, highest first, so the last sixteen bits form the word.
  task automatic xfer(input logic [31:0] d, input int n, input logic chk);
    @(negedge clock);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #(HALF);
      sclk = 1'b1;
      // An undriven pin reads unknown, so a dropped enable cannot pass as data.
      if (n - 1 - i < 16) rd_word = {rd_word[14:0], miso_oe ? miso : 1'bx};
      #(HALF);
      sclk = 1'b0;
    end
    #(HALF);
    cs_n = 1'b1;
    // A released data line must not keep showing the last bit sent.
    mosi = ~mosi;
    repeat (10) @(negedge clock);
    rd_done = chk;
    @(negedge clock);
    rd_done = 1'b0;
  endtask : xfer
endmodule : ghs_host_model

// ---- test/tb_gauge_home_seek_stall_detect.sv ----
`timescale 1ns/1ps
module tb_gauge_home_seek_stall_detect;
  typedef struct {string name; logic [15:0] exp;} ghs_tb_note_t;
  logic clock = 1'b0;
  logic arst_n, ce, sclk, cs_n, mosi, miso, miso_oe, rd_done, probe;
  logic [1:0] bemf_bit, a_en, a_neg, b_en, b_neg;
  logic [15:0] rd_word, got;
  logic [7:0] rsv;
  logic [7:0] slc [4] = '{8'hFF, 8'hFF, 8'h3F, 8'h3F};
  ghs_tb_note_t notes[$];
  ghs_tb_note_t nt;
  int err_count = 0;
  int checks_done = 0;
  int seed = 13;
  int n;

  always #2.5 clock = ~clock;

  ghs_top #(.CYC_PER_US(1)) DUT (
    .clock(clock), .arst_n(arst_n), .ce(ce), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .bemf_bit(bemf_bit), .coil_a_en(a_en),
    .coil_a_neg(a_neg), .coil_b_en(b_en), .coil_b_neg(b_neg));

  ghs_host_model host (
    .clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .rd_word(rd_word), .rd_done(rd_done));

  function automatic logic [15:0] seek_cmd(logic u, logic [1:0] sl, logic en, logic g);
    return {ghs_pkg::ADDR_SEEK_CMD, 8'h00, u, sl, en, g};
  endfunction : seek_cmd

  function automatic logic [15:0] seek_cfg(logic [7:0] pv, logic bl, logic [3:0] st);
    return {ghs_pkg::ADDR_SEEK_CFG, pv, bl, st};
  endfunction : seek_cfg

  task automatic spi(input logic [15:0] d, input int nb, input string nm = "", input logic [15:0] e = 16'h0000);
    if (nm != "") notes.push_back('{nm, e});
    host.xfer({16'h0000, d}, nb, nm != "");
  endtask : spi

  task automatic coils(input string nm, input logic [7:0] e);
    notes.push_back('{nm, {8'h00, e}});
    probe = 1'b1;
    @(negedge clock);
    probe = 1'b0;
  endtask : coils

  task automatic wait_cyc(input int c);
    repeat (c) @(negedge clock);
  endtask : wait_cyc

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // Each observed result is matched against the oldest expectation, in order.
  always @(posedge rd_done or posedge probe) begin
    nt = notes.pop_front();
    got = probe ? {8'h00, b_neg, b_en, a_neg, a_en} : rd_word;
    checks_done++;
    if (got !== nt.exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nt.name, nt.exp, got);
    end
  end

  initial begin
    #450000;
    err_count++;
    $display("watchdog expired");
    wrap_up;
  end

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    bemf_bit = 2'h3;
    probe = 1'b0;
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    wait_cyc(6);
    spi(16'h0000, 16, "status after reset", 16'h0000);
    $display("test reset done");
    // Default timing; the long step drives the accumulator into saturation.
    spi(seek_cmd(1'b1, 2'h2, 1'b1, 1'b0), 16);
    coils("first phase", 8'h01);
    spi(16'h0000, 16, "first step ones", 16'h7F04);
    wait_cyc(19500);
    spi(16'h0000, 16, "default step time", 16'h7F04);
    wait_cyc(1500);
    spi(16'h0000, 16, "saturated result", 16'h3F04);
    coils("second phase", 8'h50);
    for (int s = 0; s < 4; s++) begin
      spi(seek_cmd(1'b0, 2'(s), 1'b0, 1'b1), 16);
      spi(16'h0000, 16, "slice select", {slc[s], 8'h04});
    end
    spi(seek_cmd(1'b0, 2'h2, 1'b0, 1'b0), 16);
    coils("stopped", 8'h00);
    spi(16'h0000, 16, "held after stop", 16'h3F00);
    $display("test default seek done");
    spi(seek_cfg(8'h00, 1'b0, 4'h0), 16);
    bemf_bit = 2'h0;
    spi(seek_cmd(1'b1, 2'h2, 1'b1, 1'b1), 16);
    wait_cyc(5000);
    spi(16'h0000, 16, "negative runs on", 16'h6F08);
    coils("gauge one phase", 8'hA0);
    spi(seek_cmd(1'b0, 2'h2, 1'b0, 1'b1), 16);
    spi(seek_cmd(1'b0, 2'h2, 1'b1, 1'b0), 16);
    wait_cyc(5000);
    coils("stall stops", 8'h00);
    spi(16'h0000, 16, "active until next", 16'h6F04);
    spi(16'h0000, 16, "active cleared", 16'h6F00);
    $display("test stall done");
    spi(seek_cfg(8'hFF, 1'b0, 4'h0), 16);
    bemf_bit = 2'h3;
    spi(seek_cmd(1'b1, 2'h1, 1'b1, 1'b0), 16);
    wait_cyc(5000);
    spi(16'h0000, 16, "preload offset", 16'h1004);
    wait_cyc(4400);
    spi(16'h0000, 16, "restart each step", 16'h1004);
    spi(seek_cfg(8'hFF, 1'b1, 4'h2), 16);
    spi(seek_cmd(1'b1, 2'h2, 1'b1, 1'b0), 16);
    wait_cyc(5500);
    spi(16'h0000, 16, "longer step", 16'h7F04);
    wait_cyc(3500);
    spi(16'h0000, 16, "long blanking", 16'h1004);
    spi(seek_cmd(1'b0, 2'h2, 1'b0, 1'b0), 16);
    $display("test preload done");
    rsv = 8'($random(seed)) | 8'h01;
    spi(seek_cmd(1'b1, 2'h1, 1'b1, 1'b0) | {3'h0, rsv, 5'h00}, 16);
    coils("reserved ignored", 8'h00);
    spi(16'h0000, 16, "slice kept", 16'h1000);
    n = 17 + {$random(seed)} % 15;
    host.xfer({16'($random(seed)), seek_cmd(1'b1, 2'h2, 1'b1, 1'b0)}, n, 1'b0);
    coils("odd length ignored", 8'h00);
    host.xfer({16'($random(seed)), seek_cmd(1'b1, 2'h2, 1'b1, 1'b0)}, 32, 1'b0);
    spi(16'h0000, 16, "two word frame", 16'h7F04);
    arst_n = 1'b0;
    wait_cyc(4);
    arst_n = 1'b1;
    wait_cyc(6);
    coils("reset stops", 8'h00);
    spi(16'h0000, 16, "reset clears", 16'h0000);
    spi(seek_cmd(1'b0, 2'h2, 1'b0, 1'b0), 16);
    $display("test refusals done");
    wait_cyc(20);
    wrap_up;
  end
endmodule : tb_gauge_home_seek_stall_detect
